/* File: rtl/frn_node.sv */
// Fault report broadcast, arbitration, logging and lock-step role logic.
`timescale 1ns/1ps

module frn_node
	import frn_pkg::*;
#(
	parameter bit IS_MEM = 1'b0,
	parameter int LOC_W  = 8,
	parameter int ADDR_W = 24,
	parameter int BIT_W  = 6
) (
	// Clock and reset.
	input  wire logic                     clk,
	input  wire logic                     sys_rst,
	// Fault lines, open drain: enable high pulls the line low.
	input  wire logic [1:0]               bus_fault_line_in,
	output logic      [1:0]               bus_fault_line_out,
	output logic      [1:0]               bus_fault_line_oe,
	input  wire logic                     bus_sel,
	input  wire logic                     module_fault_line_in,
	output logic                          module_fault_line_out,
	output logic                          module_fault_line_oe,
	// Local error detection.
	input  wire logic                     err_mod,
	input  wire logic                     err_arb,
	input  wire logic                     err_par,
	input  wire logic [LOC_W-1:0]         err_loc,
	input  wire logic [LOC_W-1:0]         node_loc,
	input  wire logic                     resume,
	output logic                          halt,
	output logic                          perm_err,
	// Report log.
	output logic                          log_valid,
	output logic [frn_pkg::TYPE_W-1:0]    log_type,
	output logic [LOC_W-1:0]              log_loc,
	// Array error log.
	input  wire logic                     ecc_err,
	input  wire logic                     ecc_single,
	input  wire logic [ADDR_W-1:0]        ecc_addr,
	input  wire logic [BIT_W-1:0]         ecc_bit,
	input  wire logic                     ecc_uncorr,
	output logic                          arr_valid,
	output logic [ADDR_W-1:0]             arr_addr,
	output logic                          arr_single,
	output logic [BIT_W-1:0]              arr_bit,
	// Lock-step pairing.
	input  wire logic                     pair_en,
	input  wire logic                     is_primary,
	input  wire logic                     xfer_done,
	input  wire logic                     bus_drive_req,
	input  wire logic                     access_done,
	output logic                          active,
	output logic                          mem_bus_oe,
	output logic                          access_hold,
	output logic                          next_req_ok
);
	import frn_pkg::*;

	localparam int             DATA_W   = TYPE_W + LOC_W;
	localparam int             CNT_W    = $clog2(DATA_W);
	localparam logic [CNT_W-1:0] CNT_LAST = CNT_W'(DATA_W - 1);

	// Picks the single highest ranked type among concurrent detections.
	function automatic logic [TYPE_W-1:0] top_type(input logic m, input logic a,
	                                                input logic p);
		top_type = m ? TY_MOD : a ? TY_ARB : p ? TY_PAR : TY_NONE;
	endfunction

	frn_state_t         state_q, state_d;
	frn_phase_t         phase_q, phase_d;
	logic [DATA_W-1:0]  tx_sh_q, tx_sh_d;
	logic [DATA_W-1:0]  rx_sh_q, rx_sh_d;
	logic [CNT_W-1:0]   cnt_q, cnt_d;
	logic               tx_on_q, tx_on_d;
	logic               launched_q, launched_d;
	logic               pend_q, pend_d;
	logic               halt_q, halt_d;
	logic               oe_d;
	logic               bus_oe_q;
	logic               mod_oe_q;
	logic               log_valid_q;
	logic [DATA_W-1:0]  log_q;
	logic               perm_q;
	logic               arr_valid_q;
	logic [ADDR_W-1:0]  arr_addr_q;
	logic               arr_single_q;
	logic [BIT_W-1:0]   arr_bit_q;
	logic               pair_en_q;
	logic               active_q;
	logic               drive_q;
	logic               ppend_q;

	////////////////////////////////////////////////////////////////////////
	// Line selection and frame decoding.
	wire               sel_eff    = IS_MEM ? bus_sel : 1'b0;
	wire               bus_in     = bus_fault_line_in[sel_eff];
	wire               on_mod     = (phase_q == PH_MOD) && !IS_MEM;
	wire               line_in    = on_mod ? module_fault_line_in : bus_in;
	// A report from another bus shows up on the module line while we still idle in phase one.
	wire               mod_start  = !IS_MEM && (phase_q == PH_BUS1) && !module_fault_line_in;
	wire               rx_bit     = ~line_in;
	wire [DATA_W-1:0]  rx_next    = {rx_sh_q[DATA_W-2:0], rx_bit};
	wire               frame_done = (state_q == S_RX) && (cnt_q == CNT_LAST);
	wire               lost       = tx_on_q && !tx_sh_q[DATA_W-1] && rx_bit;
	wire               perm_hit   = IS_MEM && ppend_q && ecc_uncorr;
	wire [TYPE_W-1:0]  new_type   = perm_hit ? TY_MOD : top_type(err_mod, err_arb, err_par);
	wire [LOC_W-1:0]   new_loc    = perm_hit ? node_loc : err_loc;
	wire               new_req    = perm_hit || err_mod || err_arb || err_par;

	////////////////////////////////////////////////////////////////////////
	// Next state of the line engine.
	always_comb begin
		state_d    = state_q;
		phase_d    = phase_q;
		tx_sh_d    = tx_sh_q;
		rx_sh_d    = rx_sh_q;
		cnt_d      = cnt_q;
		tx_on_d    = tx_on_q;
		launched_d = launched_q;
		pend_d     = pend_q;
		halt_d     = halt_q;
		oe_d       = 1'b0;
		case (state_q)
			S_WAIT: begin
				if (!line_in) begin
					// A start bit: join as sender only if we launched it.
					state_d    = S_RX;
					cnt_d      = '0;
					tx_on_d    = launched_q;
					oe_d       = launched_q && tx_sh_q[DATA_W-1];
					launched_d = 1'b0;
					pend_d     = 1'b0;
					if (phase_q != PH_MOD) begin
						halt_d = 1'b1;
					end
				end else if (mod_start) begin
					// Join the module line frame as a listener; no halt until phase three.
					state_d    = S_RX;
					phase_d    = PH_MOD;
					cnt_d      = '0;
					tx_on_d    = 1'b0;
					launched_d = 1'b0;
					pend_d     = 1'b0;
				end else if (pend_q && !launched_q) begin
					oe_d       = 1'b1;
					launched_d = 1'b1;
				end else if (phase_q == PH_BUS1 && !pend_q && new_req) begin
					pend_d  = 1'b1;
					tx_sh_d = {new_type, new_loc};
				end else if (phase_q == PH_BUS1 && resume) begin
					halt_d = 1'b0;
				end
			end
			S_RX: begin
				rx_sh_d = rx_next;
				cnt_d   = cnt_q + 1'b1;
				tx_sh_d = {tx_sh_q[DATA_W-2:0], 1'b0};
				tx_on_d = tx_on_q && !lost;
				oe_d    = tx_on_d && tx_sh_q[DATA_W-2] && !frame_done;
				if (frame_done) begin
					state_d = S_WAIT;
					tx_on_d = 1'b0;
					case (phase_q)
						PH_BUS1: begin
							if (IS_MEM) begin
								phase_d = PH_BUS3;
							end else begin
								phase_d = PH_MOD;
								pend_d  = 1'b1;
								tx_sh_d = rx_next;
							end
						end
						PH_MOD: begin
							phase_d = PH_BUS3;
							pend_d  = 1'b1;
							tx_sh_d = rx_next;
						end
						default: begin
							phase_d = PH_BUS1;
						end
					endcase
				end
			end
			default: begin
				state_d = S_WAIT;
			end
		endcase
	end

	////////////////////////////////////////////////////////////////////////
	// Line engine registers.
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			state_q    <= S_WAIT;
			phase_q    <= PH_BUS1;
			tx_sh_q    <= '0;
			rx_sh_q    <= '0;
			cnt_q      <= '0;
			tx_on_q    <= 1'b0;
			launched_q <= 1'b0;
			pend_q     <= 1'b0;
			halt_q     <= 1'b0;
		end else begin
			state_q    <= state_d;
			phase_q    <= phase_d;
			tx_sh_q    <= tx_sh_d;
			rx_sh_q    <= rx_sh_d;
			cnt_q      <= cnt_d;
			tx_on_q    <= tx_on_d;
			launched_q <= launched_d;
			pend_q     <= pend_d;
			halt_q     <= halt_d;
		end
	end

	// Line drive, routed by the phase in which it was decided.
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			bus_oe_q <= 1'b0;
			mod_oe_q <= 1'b0;
		end else begin
			bus_oe_q <= oe_d && !on_mod;
			mod_oe_q <= oe_d && on_mod;
		end
	end

	// Report log keeps only the final surviving frame.
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			log_valid_q <= 1'b0;
			log_q       <= '0;
		end else if (frame_done && phase_q == PH_BUS3) begin
			log_valid_q <= 1'b1;
			log_q       <= rx_next;
		end
	end

	// Array error log; the bit index is only kept for single-bit errors.
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			arr_valid_q  <= 1'b0;
			arr_addr_q   <= '0;
			arr_single_q <= 1'b0;
			arr_bit_q    <= '0;
		end else if (IS_MEM && ecc_err) begin
			arr_valid_q  <= 1'b1;
			arr_addr_q   <= ecc_addr;
			arr_single_q <= ecc_single;
			arr_bit_q    <= ecc_single ? ecc_bit : '0;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Pair roles: primary starts active, roles alternate per transfer.
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			pair_en_q <= 1'b0;
			active_q  <= 1'b1;
			drive_q   <= 1'b0;
		end else begin
			pair_en_q <= pair_en;
			if (!pair_en) begin
				active_q <= 1'b1;
			end else if (!pair_en_q) begin
				active_q <= is_primary;
			end else if (xfer_done) begin
				active_q <= !active_q;
			end
			drive_q <= active_q && bus_drive_req && !halt_q;
		end
	end

	// Passive memory access that must finish even under a new report.
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			ppend_q <= 1'b0;
			perm_q  <= 1'b0;
		end else begin
			if (access_done) begin
				ppend_q <= 1'b0;
			end else if (IS_MEM && pair_en_q && !active_q && xfer_done) begin
				ppend_q <= 1'b1;
			end
			if (perm_hit) begin
				perm_q <= 1'b1;
			end else if (resume) begin
				perm_q <= 1'b0;
			end
		end
	end

	// Outputs.
	assign bus_fault_line_out    = 2'h0;
	assign bus_fault_line_oe     = sel_eff ? {bus_oe_q, 1'b0} : {1'b0, bus_oe_q};
	assign module_fault_line_out = 1'b0;
	assign module_fault_line_oe  = mod_oe_q;
	assign halt                  = halt_q;
	assign perm_err              = perm_q;
	assign log_valid             = log_valid_q;
	assign log_type              = log_q[DATA_W-1:LOC_W];
	assign log_loc               = log_q[LOC_W-1:0];
	assign arr_valid             = arr_valid_q;
	assign arr_addr              = arr_addr_q;
	assign arr_single            = arr_single_q;
	assign arr_bit               = arr_bit_q;
	assign active                = active_q;
	assign mem_bus_oe            = drive_q;
	assign access_hold           = ppend_q;
	assign next_req_ok           = !ppend_q;

	////////////////////////////////////////////////////////////////////////
	// Checks.
	default clocking cb @(posedge clk); endclocking
	default disable iff (sys_rst);

	sequence s_bus_start;
		state_q == S_WAIT && !line_in && phase_q != PH_MOD;
	endsequence
	sequence s_bus1_done;
		frame_done && phase_q == PH_BUS1 && !IS_MEM;
	endsequence

	a_halt_on_start: assert property (s_bus_start |=> halt_q)
		else $error("halt not raised at report start");
	a_mod_no_halt: assert property (on_mod && !halt_q |=> !halt_q)
		else $error("module line traffic halted the node");
	a_mem_no_mod: assert property (IS_MEM |-> !mod_oe_q && phase_q != PH_MOD)
		else $error("memory node used the module line");
	a_resend_mod: assert property (s_bus1_done |=> pend_q && on_mod ##1 mod_oe_q || !line_in)
		else $error("module resend did not start");
	a_log_final: assert property (frame_done && phase_q == PH_BUS3
		|=> log_valid_q && log_q == $past(rx_next))
		else $error("final report not logged");
	a_loser_quiet: assert property (state_q == S_RX && lost && !frame_done |=> !tx_on_q ##1 !bus_oe_q && !mod_oe_q)
		else $error("losing sender kept driving");
	a_active_init: assert property ($rose(pair_en) |=> ##1 active_q == $past(is_primary, 2))
		else $error("wrong initial role");
	a_role_swap: assert property (pair_en_q && pair_en && xfer_done |=> active_q != $past(active_q))
		else $error("roles did not swap");
	a_passive_drive: assert property (!active_q |=> !drive_q)
		else $error("passive module drove the bus");
	a_finish_access: assert property (ppend_q && !access_done |=> ppend_q)
		else $error("passive access dropped");
	a_perm_report: assert property (perm_hit |=> perm_q)
		else $error("permanent error not flagged");
	a_arr_bit: assert property (IS_MEM && ecc_err && !ecc_single |=> arr_bit_q == '0)
		else $error("bit logged for multi-bit error");

endmodule // frn_node

/* File: rtl/frn_pkg.sv */
// Shared constants and types for the fault report and lock-step node.
package frn_pkg;

	// Error type codes; a larger code is a higher priority and wins arbitration.
	localparam int         TYPE_W  = 2;
	localparam logic [1:0] TY_NONE = 2'h0;
	localparam logic [1:0] TY_PAR  = 2'h1;
	localparam logic [1:0] TY_ARB  = 2'h2;
	localparam logic [1:0] TY_MOD  = 2'h3;

	// Reporting phase that the node is in.
	typedef enum logic [1:0] {PH_BUS1, PH_MOD, PH_BUS3} frn_phase_t;

	// Line engine states: waiting for a frame start, or shifting a frame.
	typedef enum logic {S_WAIT, S_RX} frn_state_t;

endpackage

/* File: test/fault_report_and_lockstep_node_bench.sv */
// Self-checking bench for the fault report and lock-step node.
`timescale 1ns/1ps

module fault_report_and_lockstep_node_bench;
	import frn_pkg::*;

	localparam int LOC_W = 8;
	logic              clk, sys_rst, bus_sel, mod_in, mod_oe, resume, halt;
	logic [1:0]        bus_in, bus_oe;
	logic              err_mod, err_arb, err_par, log_valid, ecc_err, ecc_single, ecc_uncorr;
	logic [LOC_W-1:0]  err_loc, node_loc, log_loc, loc, dloc, ploc;
	logic [TYPE_W-1:0] log_type;
	logic [23:0]       ecc_addr;
	logic [5:0]        ecc_bit;
	logic              pair_en, is_primary, xfer_done, bus_drive_req, access_done;
	logic              active, mem_bus_oe, access_hold, next_req_ok, peer_bus, peer_mod;
	logic [TYPE_W+LOC_W-1:0] exp_q[$];
	logic [TYPE_W+LOC_W-1:0] last_log;
	int                num_errors, n_compared, n_logged, cycles, i, k;
	integer            seed;

	frn_node #(.LOC_W(LOC_W)) i_dut (.clk(clk), .sys_rst(sys_rst),
		.bus_fault_line_in(bus_in), .bus_fault_line_out(), .bus_fault_line_oe(bus_oe),
		.bus_sel(bus_sel), .module_fault_line_in(mod_in), .module_fault_line_out(),
		.module_fault_line_oe(mod_oe), .err_mod(err_mod), .err_arb(err_arb),
		.err_par(err_par), .err_loc(err_loc), .node_loc(node_loc), .resume(resume),
		.halt(halt), .perm_err(), .log_valid(log_valid), .log_type(log_type),
		.log_loc(log_loc), .ecc_err(ecc_err), .ecc_single(ecc_single), .ecc_addr(ecc_addr),
		.ecc_bit(ecc_bit), .ecc_uncorr(ecc_uncorr), .arr_valid(), .arr_addr(),
		.arr_single(), .arr_bit(), .pair_en(pair_en), .is_primary(is_primary),
		.xfer_done(xfer_done), .bus_drive_req(bus_drive_req), .access_done(access_done),
		.active(active), .mem_bus_oe(mem_bus_oe), .access_hold(access_hold),
		.next_req_ok(next_req_ok));

	frn_peer #(.LOC_W(LOC_W)) peer (.clk(clk), .bus_line(bus_in[0]), .mod_line(mod_in),
		.bus_pull(peer_bus), .mod_pull(peer_mod));

	// Open-drain lines with pull-ups: any enabled party pulls them low.
	assign bus_in = ~(bus_oe | {1'b0, peer_bus});
	assign mod_in = ~(mod_oe | peer_mod);

	////////////////////////////////////////////////////////////////////////////////
	// Clock and cycle ceiling.
	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end

	always @(posedge clk) begin
		cycles++;
		if (cycles == 3000) begin
			num_errors++;
			wrap_up();
		end
	end

	task automatic wrap_up();
		if (num_errors == 0 && n_compared > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask

	task automatic check(input string name, input logic [15:0] exp, input logic [15:0] got);
		n_compared++;
		if (got !== exp) begin
			$display("ERROR %s expected %h seen %h", name, exp, got);
			num_errors++;
		end
	endtask

	////////////////////////////////////////////////////////////////////////////////
	// Takes the oldest expected report whenever the log changes.
	always @(negedge clk) begin
		if (log_valid === 1'b1 && {log_type, log_loc} !== last_log) begin
			last_log = {log_type, log_loc};
			n_logged++;
			if (exp_q.size() == 0) check("log_extra", 16'h0, 16'h1);
			else check("log", exp_q.pop_front(), last_log);
		end
	end

	// Keeps the memory-side inputs except ecc_err and ecc_uncorr moving; an interface node must not react to them.
	always @(negedge clk) begin
		ecc_addr = $random(seed);
		ecc_bit = $random(seed);
		ecc_single = $random(seed);
		bus_sel = $random(seed);
		node_loc = $random(seed);
	end

	// Raises the chosen detection pulses {module, arbitration, parity} for one cycle.
	task automatic pulse_err(input logic [2:0] kinds, input logic [LOC_W-1:0] l);
		{err_mod, err_arb, err_par} = kinds;
		err_loc = l;
		@(negedge clk);
		{err_mod, err_arb, err_par} = 3'h0;
	endtask

	// Waits for the logged report, then releases the halt.
	task automatic finish_report();
		int target;
		target = n_logged + 1;
		for (int j = 0; j < 80 && n_logged < target; j++) @(negedge clk);
		check("log_seen", 16'h1, 16'(n_logged >= target));
		check("halt_held", 16'h1, halt);
		resume = 1'b1;
		@(negedge clk);
		resume = 1'b0;
		@(negedge clk);
		check("halt_clr", 16'h0, halt);
	endtask

	////////////////////////////////////////////////////////////////////////////////
	// Main sequence.
	initial begin
		seed = 32'h035098B8;
		sys_rst = 1'b1;
		{err_mod, err_arb, err_par, resume, ecc_err, ecc_uncorr} = 6'h00;
		{pair_en, is_primary, xfer_done, bus_drive_req, access_done} = 5'h00;
		{err_loc, node_loc, ecc_addr, ecc_bit, ecc_single, bus_sel} = '0;
		last_log = '1;
		repeat (10) @(negedge clk);
		sys_rst = 1'b0;
		check("rst_state", 16'h05, {halt, log_valid, active, mem_bus_oe, next_req_ok});
		// A local fault with two coincident causes: broadcast in three phases.
		loc = $random(seed);
		exp_q.push_back({TY_ARB, loc});
		pulse_err(3'h3, loc);
		for (k = 0; k < 3 && bus_oe[0] !== 1'b1; k++) @(negedge clk);
		check("bus_start", 16'h1, bus_oe[0]);
		for (k = 0; k < 3 && halt !== 1'b1; k++) @(negedge clk);
		check("halt", 16'h1, halt);
		for (k = 0; k < 20 && mod_oe !== 1'b1; k++) @(negedge clk);
		check("mod_resend", 16'h1, mod_oe);
		finish_report();
		// Simultaneous starts: higher type wins, then larger location.
		for (i = 0; i < 2; i++) begin
			loc = $random(seed);
			dloc = {i[0], loc[6:0]};
			ploc = {~i[0], loc[6:0]};
			exp_q.push_back(i == 0 ? {TY_MOD, ploc} : {TY_PAR, dloc});
			pulse_err(i == 0 ? 3'h2 : 3'h1, dloc);
			for (k = 0; k < 3 && bus_oe[0] !== 1'b1; k++) @(negedge clk);
			peer.send(1'b0, i == 0 ? TY_MOD : TY_PAR, ploc);
			finish_report();
		end
		// An earlier low-type report beats a later module fault.
		loc = $random(seed);
		exp_q.push_back({TY_PAR, loc});
		fork
			peer.send(1'b0, TY_PAR, loc);
			begin
				repeat (2) @(negedge clk);
				pulse_err(3'h4, ~loc);
				check("halt_peer", 16'h1, halt);
			end
		join
		finish_report();
		// A report arriving on the module line alone does not halt the bus until its phase-three resend.
		loc = $random(seed);
		exp_q.push_back({TY_MOD, loc});
		peer.send(1'b1, TY_MOD, loc);
		check("halt_mod", 16'h0, halt);
		finish_report();
		// Pairing as shadow: passive first, then roles swap on each transfer.
		pair_en = 1'b1;
		bus_drive_req = 1'b1;
		repeat (3) @(negedge clk);
		check("active_init", 16'h0, active);
		check("drive_passive", 16'h0, mem_bus_oe);
		for (i = 0; i < 2; i++) begin
			xfer_done = 1'b1;
			@(negedge clk);
			xfer_done = 1'b0;
			@(negedge clk);
			check("active_swap", 16'(!i[0]), active);
			check("drive_role", 16'(!i[0]), mem_bus_oe);
			check("req_ok", 16'h1, {access_hold, next_req_ok});
		end
		wrap_up();
	end

endmodule // fault_report_and_lockstep_node_bench

/* File: test/frn_peer.sv */
// Model of another interface node sharing the fault lines with the node under test.
`timescale 1ns/1ps

module frn_peer
	import frn_pkg::*;
#(
	parameter int LOC_W = 8
) (
	// Clock.
	input  wire logic clk,
	// Resolved line levels, low is dominant.
	input  wire logic bus_line,
	input  wire logic mod_line,
	// Pull-down requests onto the lines.
	output logic      bus_pull,
	output logic      mod_pull
);

	initial begin
		bus_pull = 1'b0;
		mod_pull = 1'b0;
	end

	////////////////////////////////////////////////////////////////////////////////
	// Sends one frame starting at the calling falling edge, one bit a cycle.
	// A one pulls the line low; a zero that finds the line low has lost and backs off.
	task automatic send(input logic on_mod, input logic [TYPE_W-1:0] ty,
		input logic [LOC_W-1:0] loc);
		logic [TYPE_W+LOC_W:0] frame;
		logic                  lost;
		frame = {1'b1, ty, loc};
		lost = 1'b0;
		for (int i = TYPE_W + LOC_W; i >= 0; i--) begin
			if (on_mod) mod_pull = frame[i] & !lost;
			else bus_pull = frame[i] & !lost;
			#6;
			if (!frame[i] && !(on_mod ? mod_line : bus_line)) lost = 1'b1;
			@(negedge clk);
		end
		bus_pull = 1'b0;
		mod_pull = 1'b0;
	endtask

endmodule // frn_peer
